// >>> core/bdmm_pkg.sv
package bdmm_pkg;

  // Data widths
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FILE_AW    = 8;
  localparam int unsigned INSTR_AW   = 7;
  localparam int unsigned RAM_IDX_W  = 7;
  localparam int unsigned RAM_DEPTH  = 128;
  localparam int unsigned APB_DW     = 32;
  localparam int unsigned APB_AW     = 32;

  // APB placement: byte address is four times the file index
  localparam int unsigned APB_IDX_LSB = 2;
  localparam int unsigned APB_IDX_MSB = 8;

  // Core register indices, same offset in both banks
  localparam logic [6:0] IDX_INDIRECT = 7'h00;
  localparam logic [6:0] IDX_PC_LOW   = 7'h02;
  localparam logic [6:0] IDX_STATUS   = 7'h03;
  localparam logic [6:0] IDX_POINTER  = 7'h04;
  localparam logic [6:0] IDX_PC_LATCH = 7'h0A;
  localparam logic [6:0] IDX_IRQ_CTRL = 7'h0B;

  // Layout of each bank
  localparam logic [6:0] REG_SPAN     = 7'h20;
  localparam logic [7:0] ALIAS_BASE   = 8'hF0;
  localparam logic [7:0] SMALL_BASE   = 8'h40;
  localparam logic [7:0] LARGE_BASE0  = 8'h20;
  localparam logic [7:0] LARGE_BASE1  = 8'h40;
  localparam logic [7:0] LARGE_TOP1   = 8'hBF;

  // Status field positions
  localparam int unsigned ST_BANK_SEL = 5;
  localparam int unsigned ST_UPPER    = 6;
  localparam int unsigned ST_IND_BANK = 7;

  // Reset values
  localparam logic [7:0]  CORE_RST    = 8'h00;
  localparam logic [31:0] PRDATA_RST  = 32'h00000000;

  // Kind of location a file address lands on
  typedef enum logic [1:0] {
    BDMM_KIND_NONE = 2'b00,
    BDMM_KIND_RAM  = 2'b01,
    BDMM_KIND_CORE = 2'b10,
    BDMM_KIND_IND  = 2'b11
  } bdmm_kind_e;

endpackage : bdmm_pkg

// >>> core/bdmm_map_if.sv
`timescale 1ns/100ps
interface bdmm_map_if;
  import bdmm_pkg::*;

  logic [FILE_AW-1:0]   file_addr;
  bdmm_kind_e           kind;
  logic [RAM_IDX_W-1:0] ram_idx;
  logic                 wr_en;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rdata;

  modport dec  (input file_addr, output kind, output ram_idx);
  modport ram  (input ram_idx, input wr_en, input wdata, output rdata);
  modport core (output file_addr, output wr_en, output wdata, input kind, input ram_idx, input rdata);

endinterface : bdmm_map_if

// >>> core/bdmm_decode.sv
`timescale 1ns/100ps
module bdmm_decode
  import bdmm_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  bdmm_map_if.dec map
);

  logic [7:0] folded;
  logic [7:0] offs;

  // Sort a full file address into kind and storage index
  always_comb begin
    folded      = map.file_addr;
    offs        = 8'h00;
    map.kind    = BDMM_KIND_NONE;
    map.ram_idx = '0;
    if (map.file_addr >= ALIAS_BASE) begin
      folded = {1'b0, map.file_addr[6:0]};
    end
    if (folded[6:0] == IDX_INDIRECT) begin
      map.kind = BDMM_KIND_IND;
    end else if (folded[6:0] < REG_SPAN) begin
      if (folded[6:0] == IDX_PC_LOW || folded[6:0] == IDX_STATUS || folded[6:0] == IDX_POINTER ||
          folded[6:0] == IDX_PC_LATCH || folded[6:0] == IDX_IRQ_CTRL) begin
        map.kind = BDMM_KIND_CORE;
      end
    end else if (LARGE_VARIANT) begin
      if (!folded[7]) begin
        offs        = folded - LARGE_BASE0;
        map.kind    = BDMM_KIND_RAM;
        map.ram_idx = offs[RAM_IDX_W-1:0];
      end else if (folded <= LARGE_TOP1) begin
        offs        = folded - LARGE_BASE1;
        map.kind    = BDMM_KIND_RAM;
        map.ram_idx = offs[RAM_IDX_W-1:0];
      end
    end else begin
      if (!folded[7] && folded >= SMALL_BASE) begin
        offs        = folded - SMALL_BASE;
        map.kind    = BDMM_KIND_RAM;
        map.ram_idx = offs[RAM_IDX_W-1:0];
      end
    end
  end

endmodule : bdmm_decode

// >>> core/bdmm_gpr_ram.sv
`timescale 1ns/100ps
module bdmm_byte_ram
  import bdmm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  bdmm_map_if.ram   map
);

  logic [DATA_W-1:0] mem_ff  [RAM_DEPTH];
  logic [DATA_W-1:0] nxt_mem [RAM_DEPTH];

  // One byte per location; only the indexed byte takes a write
  always_comb begin
    for (int i = 0; i < RAM_DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (map.wr_en) begin
      nxt_mem[map.ram_idx] = map.wdata;
    end
  end

  // Cleared at reset so reads never show unknowns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        mem_ff[i] <= CORE_RST;
      end
    end else begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

  assign map.rdata = mem_ff[map.ram_idx]; // Combinational read, sampled by the top

endmodule : bdmm_byte_ram

// >>> core/bdmm_top.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module bdmm_top
  import bdmm_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [DATA_W-1:0] status_flags,
  output logic      [DATA_W-1:0] file_select_pointer,
  output logic                   bank_select_bit
);

  bdmm_map_if map ();

  // Core registers, one physical copy each
  logic [DATA_W-1:0] pc_low_ff,   nxt_pc_low;
  logic [DATA_W-1:0] status_ff,   nxt_status;
  logic [DATA_W-1:0] pointer_ff,  nxt_pointer;
  logic [DATA_W-1:0] pc_latch_ff, nxt_pc_latch;
  logic [DATA_W-1:0] irq_ctrl_ff, nxt_irq_ctrl;
  logic [APB_DW-1:0] prdata_ff, nxt_prdata;

  logic [INSTR_AW-1:0] instr_addr;
  logic [FILE_AW-1:0]  direct_addr;
  logic                apb_ok;
  logic                setup_ph;
  logic                access_ph;
  logic                wr_take;
  logic [DATA_W-1:0]   rd_byte;
  logic [DATA_W-1:0]   core_byte;

  // Shared mux over the five core registers
  function automatic logic [DATA_W-1:0] core_read(
    input logic [6:0]        idx,
    input logic [DATA_W-1:0] pc_low,
    input logic [DATA_W-1:0] st,
    input logic [DATA_W-1:0] ptr,
    input logic [DATA_W-1:0] pc_latch,
    input logic [DATA_W-1:0] irq_ctrl
  );
    logic [DATA_W-1:0] v;
    v = '0;
    case (idx)
      IDX_PC_LOW:   v = pc_low;
      IDX_STATUS:   v = st;
      IDX_POINTER:  v = ptr;
      IDX_PC_LATCH: v = pc_latch;
      IDX_IRQ_CTRL: v = irq_ctrl;
      default:    v = '0;
    endcase
    return v;
  endfunction : core_read

  // APB phases; only word-aligned addresses inside the window are mapped
  assign instr_addr = paddr[APB_IDX_MSB:APB_IDX_LSB];
  assign apb_ok     = (paddr[APB_AW-1:APB_IDX_MSB+1] == '0) && (paddr[APB_IDX_LSB-1:0] == '0);
  assign setup_ph   = psel & ~penable;
  assign access_ph  = psel & penable;
  assign wr_take    = access_ph & pwrite & apb_ok;

  assign direct_addr = {status_ff[ST_BANK_SEL], instr_addr};

  // indirect slot uses pointer
  // The pointer reaches both banks on its own, so the reserved bank bits play no part
  assign map.file_addr = (instr_addr == IDX_INDIRECT) ? pointer_ff : direct_addr;
  assign map.wdata     = pwdata[DATA_W-1:0];

  assign map.wr_en = wr_take && (map.kind == BDMM_KIND_RAM);

  bdmm_decode #(
    .LARGE_VARIANT (LARGE_VARIANT)
  ) u_decode (
    .map (map.dec)
  );

  bdmm_byte_ram u_byte_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .map     (map.ram)
  );

  // Read value of the addressed location
  always_comb begin
    core_byte = core_read(map.file_addr[6:0], pc_low_ff, status_ff, pointer_ff, pc_latch_ff, irq_ctrl_ff);
    case (map.kind)
      BDMM_KIND_RAM:  rd_byte = map.rdata;
      BDMM_KIND_CORE: rd_byte = core_byte;
      default:       rd_byte = '0;
    endcase
  end

  // Next values of core registers and read data
  always_comb begin
    nxt_pc_low   = pc_low_ff;
    nxt_status   = status_ff;
    nxt_pointer  = pointer_ff;
    nxt_pc_latch = pc_latch_ff;
    nxt_irq_ctrl = irq_ctrl_ff;
    nxt_prdata   = prdata_ff;
    if (wr_take && map.kind == BDMM_KIND_CORE) begin
      case (map.file_addr[6:0])
        IDX_PC_LOW:   nxt_pc_low   = map.wdata;
        IDX_STATUS:   nxt_status   = map.wdata;
        IDX_POINTER:  nxt_pointer  = map.wdata;
        IDX_PC_LATCH: nxt_pc_latch = map.wdata;
        IDX_IRQ_CTRL: nxt_irq_ctrl = map.wdata;
        default:      nxt_pc_low   = pc_low_ff;
      endcase
    end
    // Read data caught in the setup phase, so it is a flop in the access phase
    if (setup_ph && !pwrite) begin
      nxt_prdata = apb_ok ? {{(APB_DW-DATA_W){1'b0}}, rd_byte} : PRDATA_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_low_ff   <= CORE_RST;
      status_ff   <= CORE_RST;
      pointer_ff  <= CORE_RST;
      pc_latch_ff <= CORE_RST;
      irq_ctrl_ff <= CORE_RST;
      prdata_ff   <= PRDATA_RST;
    end else begin
      pc_low_ff   <= nxt_pc_low;
      status_ff   <= nxt_status;
      pointer_ff  <= nxt_pointer;
      pc_latch_ff <= nxt_pc_latch;
      irq_ctrl_ff <= nxt_irq_ctrl;
      prdata_ff <= nxt_prdata;
    end
  end

  // Zero wait states; error for misaligned addresses and outside the register window
  assign pready              = 1'b1;
  assign pslverr             = access_ph & ~apb_ok;
  assign prdata              = prdata_ff;
  assign status_flags        = status_ff;
  assign file_select_pointer = pointer_ff;
  assign bank_select_bit     = status_ff[ST_BANK_SEL];

endmodule : bdmm_top

// >>> dv/bdmm_props.sv
`timescale 1ns/100ps
module bdmm_props
  import bdmm_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [DATA_W-1:0] status_flags,
  input wire logic [DATA_W-1:0] file_select_pointer,
  input wire logic              bank_select_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low byte of the write data, so $past sees a plain signal
  wire [7:0] wbyte = pwdata[7:0];
  sequence s_rd_setup; psel && !penable && !pwrite; endsequence
  sequence s_wr_acc; psel && penable && pwrite; endsequence
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_bank; bank_select_bit == status_flags[ST_BANK_SEL]; endproperty
  a_bank: assert property (p_bank) else $error("bank bit differs from status");
  property p_upper; prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("read data wider than a byte");
  property p_err; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned access not flagged");
  property p_st; s_wr_acc ##0 paddr == 32'h0000000C |=> status_flags == $past(wbyte); endproperty
  a_st: assert property (p_st) else $error("status write lost");
  property p_ptr; s_wr_acc ##0 paddr == 32'h00000010 |=> file_select_pointer == $past(wbyte); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write lost");
  property p_sfr0; s_rd_setup ##0 paddr[8:2] == 7'h01 |=> prdata == 32'h00000000; endproperty
  a_sfr0: assert property (p_sfr0) else $error("empty register slot not zero");
  property p_drop; s_wr_acc ##0 pslverr |=> $stable(status_flags) && $stable(file_select_pointer); endproperty
  a_drop: assert property (p_drop) else $error("refused write changed state");
endmodule : bdmm_props
bind bdmm_top bdmm_props i_props (.*);

// >>> dv/bdmm_cpu_model.sv
`timescale 1ns/100ps
module bdmm_cpu_model
  import bdmm_pkg::*;
(
  input  wire logic              pclk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [APB_AW-1:0] paddr,
  output logic      [APB_DW-1:0] pwdata,
  input  wire logic [APB_DW-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  output logic                   to_hit
);
  // Idle bus at time zero
  initial begin
    {psel, penable, pwrite, to_hit} = 4'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
  end
  // One transfer; request held until pready seen, then address inverted so stale values show
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) to_hit <= 1'b1;
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
  endtask : xfer
endmodule : bdmm_cpu_model

// >>> dv/banked_data_memory_map_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module banked_data_memory_map_bench;
  import bdmm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bank_select_bit, to_hit, err;
  logic [31:0] paddr, pwdata, prdata, prdata_s;
  logic [7:0]  status_flags, file_select_pointer, q;
  int          miscompares = 0;
  int          checks_done = 0;
  bdmm_top i_dut (.*);
  bdmm_cpu_model i_cpu (.*);
  // Small variant on the same bus; only its read data is judged
  bdmm_top #(
    .LARGE_VARIANT (1'b0)
  ) i_dut_small (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata_s),
    .pready              (),
    .pslverr             (),
    .status_flags        (),
    .file_select_pointer (),
    .bank_select_bit     ()
  );
  // Clock; reset is driven by the main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wr(input logic [6:0] f, input logic [7:0] d);
    i_cpu.xfer(1'b1, {23'h000000, f, 2'b00}, d, q, err);
  endtask : wr
  task automatic rd(input logic [6:0] f, input logic [7:0] e);
    i_cpu.xfer(1'b0, {23'h000000, f, 2'b00}, 8'h00, q, err);
    `CHK(q, e)
  endtask : rd
  task automatic bank(input logic b);
    wr(7'h03, {2'b00, b, 5'h00});
  endtask : bank
  task automatic t_gpr();
    wr(7'h20, 8'hAA);
    wr(7'h7F, 8'h55);
    rd(7'h20, 8'hAA);
    bank(1'b1);
    @(negedge pclk);
    `CHK(bank_select_bit, 1'b1)
    rd(7'h7F, 8'h55);
    wr(7'h7F, 8'h3C);
    wr(7'h20, 8'h99);
    wr(7'h40, 8'h77);
    rd(7'h20, 8'h99);
    `CHK(prdata_s, 32'h00000000)
    rd(7'h40, 8'h00);
    bank(1'b0);
    rd(7'h7F, 8'h3C);
    rd(7'h20, 8'hAA);
  endtask : t_gpr
  task automatic t_core();
    bank(1'b1);
    wr(7'h04, 8'h5A);
    bank(1'b0);
    `CHK(file_select_pointer, 8'h5A)
    rd(7'h03, 8'h00);
    wr(7'h01, 8'hFF);
    rd(7'h01, 8'h00);
  endtask : t_core
  task automatic t_ind();
    wr(7'h04, 8'hA1);
    wr(7'h00, 8'h6B);
    bank(1'b1);
    rd(7'h21, 8'h6B);
    bank(1'b0);
    rd(7'h00, 8'h6B);
    wr(7'h04, 8'h80);
    wr(7'h00, 8'h11);
    rd(7'h00, 8'h00);
  endtask : t_ind
  task automatic t_err();
    i_cpu.xfer(1'b1, 32'h0000000D, 8'h20, q, err);
    `CHK(err, 1'b1)
    @(negedge pclk);
    `CHK(status_flags, 8'h00)
    i_cpu.xfer(1'b0, 32'h00000200, 8'h00, q, err);
    `CHK({err, q}, 9'h100)
  endtask : t_err
  // Same traffic on both variants; small one stores only from 40h up in bank 0
  task automatic t_small();
    wr(7'h30, 8'hE1);
    rd(7'h30, 8'hE1);
    `CHK(prdata_s, 32'h00000000)
    wr(7'h41, 8'hC3);
    rd(7'h41, 8'hC3);
    `CHK(prdata_s, 32'h000000C3)
  endtask : t_small
  task automatic wrap_up();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // A hung transfer ends the run
  always @(posedge to_hit) begin
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({status_flags, file_select_pointer, prdata}, 48'h0)
    t_gpr();
    t_core();
    t_ind();
    t_err();
    t_small();
    wrap_up();
  end
endmodule : banked_data_memory_map_bench
